// >>> design/ilr_pkg.sv
// ilr_pkg: shared constants and carriers for the response record framer
// assumes: byte-wide transmit stream toward the slave link frame logic
package ilr_pkg;

  // ==========================================================
  // extended capability header bits
  localparam int XH_RSVD7   = 7;
  localparam int XH_NATION  = 6;
  localparam int XH_STATUS  = 5;
  localparam int XH_NAME    = 4;
  localparam int XH_RSVD3   = 3;
  localparam int XH_READ    = 2;
  localparam int XH_WRBLK   = 1;
  localparam int XH_WRONE   = 0;
  localparam logic [7:0] XH_RSVD_MASK = 8'h88;

  // ==========================================================
  // extended record limits
  localparam int XREC_MIN   = 1;
  localparam int XREC_MAX   = 15;
  localparam int XREC_DEF   = 6;
  localparam logic [7:0] REG_ADDR_MAX = 8'h7F;
  localparam logic [7:0] NATION_LO    = 8'h02;
  localparam logic [7:0] NATION_HI    = 8'h1D;

  // ==========================================================
  // basic capability header bits
  localparam int BH_POS16   = 5;
  localparam int BH_EXTDESC = 3;

  // ==========================================================
  // poll header fields
  localparam int PH_AXSET   = 7;
  localparam int PH_CT_HI   = 6;
  localparam int PH_CT_LO   = 4;
  localparam int PH_STATUS  = 3;
  localparam int PH_READY   = 2;
  localparam int PH_AX_HI   = 1;
  localparam int PH_AX_LO   = 0;
  localparam int CHAR_MAX   = 8;
  localparam int KEYS_MAX   = 128;

  typedef enum logic [2:0] {
    ILR_CT_NONE  = 3'h0,
    ILR_CT_RSV1  = 3'h1,
    ILR_CT_ASCII = 3'h2,
    ILR_CT_BIN   = 3'h3,
    ILR_CT_KEY1  = 3'h4,
    ILR_CT_RSV2  = 3'h5,
    ILR_CT_KEY2  = 3'h6,
    ILR_CT_KEY3  = 3'h7
  } ilr_ctype_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic       nation_en;
    logic       status_cmd;
    logic       name_cmd;
    logic       read_en;
    logic       wr_blk;
    logic       wr_one;
    logic [6:0] read_max;
    logic [6:0] write_max;
    logic [15:0] buf_len;
    logic [7:0] nation;
  } ilr_xcap_t;

  typedef struct packed {
    logic       axis_set2;
    ilr_ctype_t ctype;
    logic       status_req;
    logic       ready;
    logic [1:0] axes;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
    logic [3:0] nchar;
    logic [63:0] chars;
  } ilr_poll_t;

  typedef struct packed {
    logic [7:0] data;
    logic       echo;
    logic       last;
  } ilr_byte_t;

endpackage

// >>> design/ilr_xhdr.sv
// ilr_xhdr: builds the extended capability header and byte count
// assumes: capability inputs held stable while a record is sent
`timescale 1ns/1ps
`default_nettype none
module ilr_xhdr (
  // capability in
  input  wire ilr_pkg::ilr_xcap_t i_cap,
  // header out
  output logic [7:0]              o_hdr,
  output logic [3:0]              o_len
);
  import ilr_pkg::*;

  always_comb begin
    o_hdr = 8'h00;
    o_hdr[XH_NATION] = i_cap.nation_en;
    o_hdr[XH_STATUS] = i_cap.status_cmd;  // see R07
    o_hdr[XH_NAME]   = i_cap.name_cmd;    // see R07
    o_hdr[XH_READ]   = i_cap.read_en;
    o_hdr[XH_WRBLK]  = i_cap.wr_blk;
    o_hdr[XH_WRONE]  = i_cap.wr_one;
    o_hdr = o_hdr & ~XH_RSVD_MASK;        // see R05
    // header always, then flagged fields only; 1..6 bytes
    o_len = 4'h1 + {3'h0, i_cap.read_en}
          + {3'h0, i_cap.wr_blk | i_cap.wr_one}
          + {2'h0, i_cap.wr_blk, 1'b0}
          + {3'h0, i_cap.nation_en};      // see R02 see R04
  end

endmodule
`default_nettype wire

// >>> design/ilr_pick.sv
// ilr_pick: selects one byte from a 16-entry byte list by index
// assumes: list packed with entry 0 in the low byte
`timescale 1ns/1ps
`default_nettype none
module ilr_pick (
  // list and index
  input  wire logic [127:0] i_list,
  input  wire logic [3:0]   i_idx,
  // selected byte
  output logic [7:0]        o_byte
);
  always_comb begin
    o_byte = i_list[{i_idx, 3'h0} +: 8];
  end
endmodule
`default_nettype wire

// >>> design/ilr_framer.sv
// ilr_framer: device-side formatter of extended capability and poll
// records, each followed by the echoed or bumped command frame.
// assumes: host issues one command at a time, the byte sink may stall
`timescale 1ns/1ps
`default_nettype none

// How it works
// R01: after extended record bytes, echo the received command frame unchanged
// R02: extended record is 1 to 15 bytes, six positions defined
// R03: host addresses extended describe to one device only
// R04: extended record always starts with the capability header byte
// R05: header bits 7 and 3 always sent as zero
// R06: header bit 6 adds nationality byte after buffer length high byte
// R07: bits 5 and 4 flag report-status and report-name support
// R08: bit 2 adds read maximum byte right after header
// R09: bits 1 or 0 add write maximum byte
// R10: read maximum is highest read address, at most 127
// R11: write maximum is highest write address, at most 127
// R12: block write adds buffer length minus one, low byte first
// R13: nationality code is eight bits, reserved codes flagged
// R14: after poll record send poll command plus frame count if room
// R15: poll header bit 7 selects second axis set
// R16: bits 6..4 give character type, at most 8 characters
// R17: keycode set 2 uses its low bit as press or release
// R18: bit 3 requests a status check
// R19: bit 2 says device ready for host data
// R20: bits 1..0 give axes reported
// R21: each axis low byte, then high byte in 16-bit format
// R22: one character type per record
// R23: 16-bit format follows basic header bit 5
// R24: basic header bit 3 advertises extended describe
// R25: optional fields in fixed order, absent when flag clear
module ilr_framer (
  // clock and reset
  input  wire logic                i_ref_clk,
  input  wire logic                i_reset_n,
  // commands from the link
  input  wire logic                i_xdesc_req,
  input  wire logic                i_poll_req,
  input  wire logic [7:0]          i_cmd,
  input  wire logic [4:0]          i_fifo_room,
  // device description
  input  wire logic [7:0]          i_basic_hdr,
  input  wire ilr_pkg::ilr_xcap_t  i_xcap,
  input  wire ilr_pkg::ilr_poll_t  i_poll,
  // byte stream out
  input  wire logic                i_tx_ready,
  output logic                     o_tx_valid,
  output ilr_pkg::ilr_byte_t       o_tx,
  // status
  output logic                     o_busy,
  output logic                     o_xdesc_cap,
  output logic                     o_poll_skip,
  output logic                     o_nation_bad
);
  import ilr_pkg::*;

  // ==========================================================
  // state
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SEND = 4'b0010,
    ST_ECHO = 4'b0100,
    ST_DONE = 4'b1000
  } ilr_state_t;

  ilr_state_t   state;
  ilr_state_t   next_state;
  logic [127:0] list;
  logic [3:0]   len;
  logic [3:0]   idx;
  logic [7:0]   echo_cmd;
  logic [7:0]   xhdr;
  logic [3:0]   xlen;
  logic [7:0]   pick;
  logic         tx_take;

  ilr_xhdr u_xhdr (
    .i_cap (i_xcap),
    .o_hdr (xhdr),
    .o_len (xlen)
  );

  ilr_pick u_pick (
    .i_list (list),
    .i_idx  (idx),
    .o_byte (pick)
  );

  assign tx_take = o_tx_valid & i_tx_ready;

  // ==========================================================
  // extended record assembly
  logic [127:0] xlist;
  logic [3:0]   xpos;
  always_comb begin
    xlist = '0;
    xpos  = 4'h1;
    xlist[7:0] = xhdr;                                   // see R04
    if (i_xcap.read_en) begin                            // see R08 see R25
      xlist[{xpos, 3'h0} +: 8] = {1'b0, i_xcap.read_max}; // see R10
      xpos = xpos + 4'h1;
    end
    if (i_xcap.wr_blk | i_xcap.wr_one) begin             // see R09
      xlist[{xpos, 3'h0} +: 8] = {1'b0, i_xcap.write_max}; // see R11
      xpos = xpos + 4'h1;
    end
    if (i_xcap.wr_blk) begin                             // see R12
      xlist[{xpos, 3'h0} +: 8] = i_xcap.buf_len[7:0];
      xpos = xpos + 4'h1;
      xlist[{xpos, 3'h0} +: 8] = i_xcap.buf_len[15:8];
      xpos = xpos + 4'h1;
    end
    if (i_xcap.nation_en) begin                          // see R06
      xlist[{xpos, 3'h0} +: 8] = i_xcap.nation;          // see R13
    end
  end

  // ==========================================================
  // poll record assembly
  logic [127:0] plist;
  logic [3:0]   ppos;
  logic [7:0]   phdr;
  logic [3:0]   nch;
  logic         wide;
  logic [1:0]   naxes;
  logic [47:0]  axv;
  always_comb begin
    plist = '0;
    ppos  = 4'h1;
    wide  = i_basic_hdr[BH_POS16];                       // see R23
    naxes = i_poll.axes;
    axv   = {i_poll.z, i_poll.y, i_poll.x};
    // reserved character types carry nothing
    nch   = (i_poll.ctype == ILR_CT_NONE || i_poll.ctype == ILR_CT_RSV1 ||
             i_poll.ctype == ILR_CT_RSV2) ? 4'h0 :
            (i_poll.nchar > 4'(CHAR_MAX)) ? 4'(CHAR_MAX) : i_poll.nchar;
    phdr  = {i_poll.axis_set2,                           // see R15
             (nch == 4'h0) ? ILR_CT_NONE : i_poll.ctype, // see R16 see R22
             i_poll.status_req,                          // see R18
             i_poll.ready,                               // see R19
             naxes};                                     // see R20
    plist[7:0] = phdr;
    for (int a = 0; a < 3; a++) begin
      if (2'(a) < naxes) begin                           // see R21
        plist[{ppos, 3'h0} +: 8] = axv[a*16 +: 8];
        ppos = ppos + 4'h1;
        if (wide) begin
          plist[{ppos, 3'h0} +: 8] = axv[a*16+8 +: 8];
          ppos = ppos + 4'h1;
        end
      end
    end
    for (int c = 0; c < CHAR_MAX; c++) begin
      if (4'(c) < nch) begin
        // keycode set 2 bytes pass as given, low bit is the transition
        plist[{ppos, 3'h0} +: 8] = i_poll.chars[c*8 +: 8]; // see R17
        ppos = ppos + 4'h1;
      end
    end
  end

  // ==========================================================
  // sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (i_xdesc_req | i_poll_req) begin
          next_state = ST_SEND;
        end
      end
      ST_SEND: begin
        if (tx_take && idx == len - 4'h1) begin
          next_state = ST_ECHO;
        end
      end
      ST_ECHO: begin
        if (tx_take) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // record capture
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      list        <= '0;
      len         <= 4'h0;
      echo_cmd    <= 8'h00;
      o_poll_skip <= 1'b0;
    end else begin
      o_poll_skip <= 1'b0;
      if (state == ST_IDLE && i_xdesc_req) begin
        list     <= xlist;
        len      <= xlen;                                // see R02
        echo_cmd <= i_cmd;                               // see R01
      end else if (state == ST_IDLE && i_poll_req) begin
        list <= plist;
        len  <= ppos;
        // bumped poll command only when the controller fifo has room
        if ({1'b0, i_fifo_room} > {1'b0, ppos}) begin    // see R14
          echo_cmd <= i_cmd + {4'h0, ppos};
        end else begin
          echo_cmd <= i_cmd;
          o_poll_skip <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // byte output
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      idx        <= 4'h0;
      o_tx_valid <= 1'b0;
      o_tx       <= '0;
    end else begin
      unique case (next_state)
        ST_SEND: begin
          if (state == ST_IDLE) begin
            idx <= 4'h0;
          end else if (tx_take) begin
            idx <= idx + 4'h1;
          end
        end
        default: begin
          idx <= idx;
        end
      endcase
      if (state == ST_IDLE && next_state == ST_SEND) begin
        o_tx_valid <= 1'b0;
      end else if (state == ST_SEND && !o_tx_valid) begin
        o_tx_valid <= 1'b1;
        o_tx       <= '{data: pick, echo: 1'b0, last: 1'b0};
      end else if (state == ST_SEND && tx_take && idx != len - 4'h1) begin
        o_tx <= '{data: list[{idx + 4'h1, 3'h0} +: 8],
                  echo: 1'b0, last: 1'b0};
      end else if (state == ST_SEND && tx_take) begin
        // trailing command frame marks end of record
        o_tx <= '{data: echo_cmd, echo: 1'b1, last: 1'b1}; // see R01 see R14
      end else if (state == ST_ECHO && tx_take) begin
        o_tx_valid <= 1'b0;
        o_tx       <= '0;
      end
    end
  end

  // ==========================================================
  // status
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_busy       <= 1'b0;
      o_xdesc_cap  <= 1'b0;
      o_nation_bad <= 1'b0;
    end else begin
      o_busy       <= (next_state != ST_IDLE);
      o_xdesc_cap  <= i_basic_hdr[BH_EXTDESC];           // see R24
      o_nation_bad <= i_xcap.nation_en &&                // see R13
                      (i_xcap.nation < NATION_LO ||
                       i_xcap.nation > NATION_HI);
    end
  end

endmodule
`default_nettype wire

// >>> testbench/ilr_framer_sva.sv
// ilr_framer_sva: port-level checks of the response record framer
// assumes: bound to ilr_framer, description inputs stable per record
`timescale 1ns/1ps
`default_nettype none
module ilr_framer_sva
  import ilr_pkg::*;
(
  // clock and reset
  input wire logic               i_ref_clk,
  input wire logic               i_reset_n,
  // requests and description
  input wire logic               i_xdesc_req,
  input wire logic               i_poll_req,
  input wire logic [7:0]         i_basic_hdr,
  input wire ilr_pkg::ilr_xcap_t i_xcap,
  input wire ilr_pkg::ilr_poll_t i_poll,
  // stream and status
  input wire logic               i_tx_ready,
  input wire logic               o_tx_valid,
  input wire ilr_pkg::ilr_byte_t o_tx,
  input wire logic               o_busy,
  input wire logic               o_xdesc_cap,
  input wire logic               o_poll_skip
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  // ==========================================================
  // record tracking
  logic       idle;
  logic       take;
  logic       first;
  logic       kx;
  logic [1:0] up;
  assign idle = !o_busy && !o_tx_valid;
  assign take = o_tx_valid && i_tx_ready;
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      first <= 1'h0;
      kx    <= 1'h0;
    end else if (idle && (i_xdesc_req || i_poll_req)) begin
      first <= 1'h1;
      kx    <= i_xdesc_req;
    end else if (take) begin
      first <= 1'h0;
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      up <= 2'h0;
    end else if (up != 2'h3) begin
      up <= up + 2'h1;
    end
  end
  // ==========================================================
  // sequences and assertions
  sequence s_start;
    idle && (i_xdesc_req || i_poll_req);
  endsequence
  sequence s_answer;
    o_busy ##1 o_tx_valid;
  endsequence
  sequence s_close;
    !o_tx_valid ##1 !o_busy;
  endsequence
  answer_time_a: assert property (s_start |=> s_answer)
    else $error("first byte not two cycles after request");
  rsvd_zero_a: assert property (o_tx_valid && first && kx |->
    (o_tx.data & XH_RSVD_MASK) == 8'h00)
    else $error("reserved header bits set");
  xhdr_flags_a: assert property (o_tx_valid && first && kx |->
    o_tx.data[6:4] == {i_xcap.nation_en, i_xcap.status_cmd,
    i_xcap.name_cmd} && o_tx.data[2:0] == {i_xcap.read_en,
    i_xcap.wr_blk, i_xcap.wr_one})
    else $error("extended header flags wrong");
  poll_hdr_a: assert property (o_tx_valid && first && !kx |->
    o_tx.data[7] == i_poll.axis_set2 && o_tx.data[3:0] ==
    {i_poll.status_req, i_poll.ready, i_poll.axes})
    else $error("poll header status or axes wrong");
  hold_byte_a: assert property (o_tx_valid && !i_tx_ready |=>
    o_tx_valid && $stable(o_tx))
    else $error("byte changed before it was taken");
  echo_last_a: assert property (o_tx_valid && o_tx.last |-> o_tx.echo)
    else $error("trailing byte not marked as echo");
  close_rec_a: assert property (take && o_tx.last |=> s_close)
    else $error("record did not close after trailer");
  skip_pulse_a: assert property (o_poll_skip |=> !o_poll_skip)
    else $error("skip flag longer than one cycle");
  ext_flag_a: assert property (up == 2'h3 && $stable(i_basic_hdr) |->
    o_xdesc_cap == i_basic_hdr[BH_EXTDESC])
    else $error("extended describe flag wrong");
endmodule
`default_nettype wire

// >>> testbench/ilr_host.sv
// ilr_host: host link controller model, issues commands, collects bytes
// assumes: one framer on the link, bench reads got and lost
`timescale 1ns/1ps
`default_nettype none
module ilr_host
  import ilr_pkg::*;
(
  // clock
  input  wire logic               i_ref_clk,
  // command side
  output logic                    o_xdesc_req,
  output logic                    o_poll_req,
  output logic [7:0]              o_cmd,
  // byte stream
  output logic                    o_tx_ready,
  input  wire logic               i_tx_valid,
  input  wire ilr_pkg::ilr_byte_t i_tx
);
  ilr_byte_t got[$];
  logic      lost;
  initial begin
    o_xdesc_req = 1'h0;
    o_poll_req  = 1'h0;
    o_cmd       = 8'h00;
    o_tx_ready  = 1'h0;
    lost        = 1'h0;
  end
  // addressed to this device alone, never broadcast
  task automatic issue(input logic poll, input logic [7:0] cmd,
                       input int stall);
    int n;
    got.delete();
    @(posedge i_ref_clk);
    #1;
    o_xdesc_req = !poll;
    o_poll_req  = poll;
    o_cmd       = cmd;
    @(posedge i_ref_clk);
    #1;
    o_xdesc_req = 1'h0;
    o_poll_req  = 1'h0;
    o_cmd       = ~cmd;
    for (n = 0; n < 300; n++) begin
      o_tx_ready = (stall == 0) || (n % stall == 0);
      @(posedge i_ref_clk);
      if (i_tx_valid && o_tx_ready) begin
        got.push_back(i_tx);
        if (i_tx.last) break;
      end
      #1;
    end
    if (n == 300) lost = 1'h1;
    #1;
    o_tx_ready = 1'h0;
    repeat (3) @(posedge i_ref_clk);
    // hand back off the edge so the bench never changes inputs on it
    #1;
  endtask
endmodule
`default_nettype wire

// >>> testbench/tb.sv
// tb: self-checking bench for the response record framer
// assumes: host model issues commands, bench drives the description
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ilr_pkg::*;
  logic       ref_clk = 1'h0;
  logic       reset_n = 1'h0;
  logic       xreq, preq, rdy, valid, busy, cap, skip, nbad;
  logic       skip_seen = 1'h0;
  logic [7:0] cmd;
  logic [7:0] bhdr;
  logic [4:0] room;
  ilr_xcap_t  xcap;
  ilr_poll_t  poll;
  ilr_byte_t  tx;
  logic [7:0] ex[$];
  int         mismatches = 0;
  int         n_tests = 0;
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (skip === 1'h1) skip_seen = 1'h1;
  ilr_framer i_ilr_framer (.i_ref_clk(ref_clk), .i_reset_n(reset_n),
    .i_xdesc_req(xreq), .i_poll_req(preq), .i_cmd(cmd),
    .i_fifo_room(room), .i_basic_hdr(bhdr), .i_xcap(xcap),
    .i_poll(poll), .i_tx_ready(rdy), .o_tx_valid(valid), .o_tx(tx),
    .o_busy(busy), .o_xdesc_cap(cap), .o_poll_skip(skip),
    .o_nation_bad(nbad));
  ilr_host i_ilr_host (.i_ref_clk(ref_clk), .o_xdesc_req(xreq),
    .o_poll_req(preq), .o_cmd(cmd), .o_tx_ready(rdy),
    .i_tx_valid(valid), .i_tx(tx));
  // ==========================================================
  // compare, expectations, record runs
  task automatic chk(input string what, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic test_done();
    $display("tests %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic void xexp(input logic [7:0] c);
    ex.delete();
    ex.push_back({1'h0, xcap.nation_en, xcap.status_cmd, xcap.name_cmd,
      1'h0, xcap.read_en, xcap.wr_blk, xcap.wr_one});
    if (xcap.read_en) ex.push_back({1'h0, xcap.read_max});
    if (xcap.wr_blk || xcap.wr_one) ex.push_back({1'h0, xcap.write_max});
    if (xcap.wr_blk) ex.push_back(xcap.buf_len[7:0]);
    if (xcap.wr_blk) ex.push_back(xcap.buf_len[15:8]);
    if (xcap.nation_en) ex.push_back(xcap.nation);
    ex.push_back(c);
  endfunction
  function automatic void pexp(input logic [7:0] c);
    logic [47:0] ax;
    logic [2:0]  ct;
    int          k;
    ax = {poll.z, poll.y, poll.x};
    ct = (poll.nchar == 4'h0) ? 3'h0 : poll.ctype;
    ex.delete();
    ex.push_back({poll.axis_set2, ct, poll.status_req, poll.ready,
      poll.axes});
    for (k = 0; k < poll.axes; k++) begin
      ex.push_back(ax[16*k +: 8]);
      if (bhdr[BH_POS16]) ex.push_back(ax[16*k+8 +: 8]);
    end
    for (k = 0; k < poll.nchar; k++) ex.push_back(poll.chars[8*k +: 8]);
    k = ex.size();
    ex.push_back(room > k ? c + 8'(k) : c);
  endfunction
  task automatic run(input logic p, input logic [7:0] c, input int st);
    int        k;
    ilr_byte_t lb;
    i_ilr_host.issue(p, c, st);
    if (i_ilr_host.lost) begin
      mismatches++;
      test_done();
    end
    chk("length", 8'(ex.size()), 8'(i_ilr_host.got.size()));
    for (k = 0; k < ex.size() && k < i_ilr_host.got.size(); k++)
      chk("byte", ex[k], i_ilr_host.got[k].data);
    if (i_ilr_host.got.size() > 0) begin
      lb = i_ilr_host.got[$];
      chk("trailer", 8'h03, {6'h00, lb.echo, lb.last});
    end
  endtask
  // ==========================================================
  // scenarios
  initial begin
    bhdr = 8'h28;
    room = 5'h1F;
    xcap = '{1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 7'h7F, 7'h0F,
      16'h03FF, 8'h1D};
    poll = '0;
    repeat (3) @(posedge ref_clk);
    #1 reset_n = 1'h1;
    xexp(8'h10);
    run(1'h0, 8'h10, 3);
    chk("nation flag", 8'h00, {7'h00, nbad});
    chk("ext flag", 8'h01, {7'h00, cap});
    xcap = '0;
    xexp(8'h11);
    run(1'h0, 8'h11, 0);
    xcap = '{1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 7'h00, 7'h05,
      16'hFFFF, 8'h20};
    xexp(8'h12);
    run(1'h0, 8'h12, 2);
    chk("nation flag", 8'h01, {7'h00, nbad});
    poll = '{1'h1, ILR_CT_KEY2, 1'h1, 1'h1, 2'h3, 16'h1234, 16'h5678,
      16'h9ABC, 4'h8, 64'h0F0E_0D0C_0B0A_0302};
    pexp(8'h20);
    run(1'h1, 8'h20, 2);
    bhdr = 8'h08;
    room = 5'h06;
    poll = '{1'h0, ILR_CT_BIN, 1'h0, 1'h0, 2'h2, 16'h1111, 16'h2222,
      16'h3333, 4'h3, 64'h0000_0000_00C3_B2A1};
    pexp(8'h21);
    run(1'h1, 8'h21, 0);
    chk("skip flag", 8'h01, {7'h00, skip_seen});
    room = 5'h1F;
    for (int t = 0; t < 8; t++) begin
      poll.ctype = ilr_ctype_t'(t);
      poll.axes  = 2'h1;
      poll.nchar = (t == 0 || t == 1 || t == 5) ? 4'h0 : 4'h2;
      pexp(8'h30 + 8'(t));
      run(1'h1, 8'h30 + 8'(t), 0);
    end
    test_done();
  end
endmodule
bind ilr_framer ilr_framer_sva i_ilr_framer_sva (.i_ref_clk(i_ref_clk),
  .i_reset_n(i_reset_n), .i_xdesc_req(i_xdesc_req),
  .i_poll_req(i_poll_req), .i_basic_hdr(i_basic_hdr), .i_xcap(i_xcap),
  .i_poll(i_poll), .i_tx_ready(i_tx_ready), .o_tx_valid(o_tx_valid),
  .o_tx(o_tx), .o_busy(o_busy), .o_xdesc_cap(o_xdesc_cap),
  .o_poll_skip(o_poll_skip));
`default_nettype wire
